// file: hdl/ncp_pkg.sv
package ncp_pkg;
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_PHASE = 8'h12;
  localparam logic [7:0] IDX_RSVD_A = 8'h13;
  localparam logic [7:0] IDX_FREQ_LO = 8'h14;
  localparam logic [7:0] IDX_FREQ_HI = 8'h15;
  localparam logic [7:0] IDX_RSVD_B = 8'h16;
  localparam logic [7:0] IDX_RSVD_C = 8'h17;
  localparam logic [7:0] IDX_SYNTH_CTL = 8'h18;
  localparam logic [7:0] IDX_SYNTH_DIV = 8'h19;
  localparam logic [7:0] IDX_VCO_TUNE = 8'h1a;
  localparam logic [7:0] IDX_AUTOLOAD = 8'h1f;
  localparam int ADDR_LSB = 2;

  // synth_control fields
  localparam int CTL_LF_CLAMP = 12;
  localparam int CTL_NSYNC_EN = 11;
  localparam int CTL_SYNTH_EN = 10;
  localparam int CTL_CP_HI = 7;
  localparam int CTL_CP_LO = 6;
  localparam int CTL_PRE_HI = 5;
  localparam int CTL_PRE_LO = 3;
  localparam int CTL_LFV_HI = 2;
  localparam int CTL_LFV_LO = 0;
  localparam logic [15:0] CTL_RESET = 16'h2808;
  localparam logic [15:0] CTL_WMASK = 16'hfff8;

  // synth_divider fields
  localparam int DIV_M_HI = 15;
  localparam int DIV_M_LO = 8;
  localparam int DIV_N_HI = 7;
  localparam int DIV_N_LO = 4;
  localparam int DIV_BIAS_HI = 3;
  localparam int DIV_BIAS_LO = 2;
  localparam logic [15:0] DIV_RESET = 16'h0440;
  localparam logic [15:0] DIV_WMASK = 16'hfffc;

  // vco coarse band register
  localparam int VCO_HI = 15;
  localparam int VCO_LO = 10;
  localparam logic [15:0] VCO_RESET = 16'h0000;
  localparam logic [15:0] VCO_WMASK = 16'hfc00;

  // mixer autoload config, bit 0 enables auto-sync on phase write
  localparam int AUTOLOAD_EN = 0;
  localparam logic [15:0] AUTOLOAD_RESET = 16'h0000;
  localparam logic [15:0] RSVD_VALUE = 16'h0000;

  typedef enum logic [1:0] {
    CP_NONE = 2'h0,
    CP_SINGLE = 2'h1,
    CP_UNUSED = 2'h2,
    CP_DUAL = 2'h3
  } ncp_pump_t;

  typedef struct packed {
    logic enable;
    logic bypass;
    logic lf_clamp;
    logic nsync_en;
    ncp_pump_t charge_pump_sel;
    logic [3:0] prescale;
    logic [7:0] m_ratio;
    logic m_valid;
    logic [4:0] n_ratio;
    logic [1:0] bias_trim;
    logic [5:0] vco_band;
  } ncp_pll_t;
endpackage

// file: hdl/ncp_nco.sv
`timescale 1ns/1ns
`default_nettype none
module ncp_nco (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic load_i,
  input wire logic [31:0] freq_i,
  input wire logic [15:0] phase_i,
  output logic [15:0] lut_addr_o,
  output logic [31:0] freq_active_o
);
  typedef struct packed {
    logic [31:0] acc;
    logic [31:0] freq;
    logic [15:0] phase;
    logic [15:0] addr;
  } ncp_nco_st_t;

  ncp_nco_st_t st;
  ncp_nco_st_t next_st;

  always_comb begin
    next_st = st;
    next_st.acc = st.acc + st.freq;
    if (load_i) begin
      next_st.freq = freq_i;
      next_st.phase = phase_i;
    end
    next_st.addr = st.acc[31:16] + st.phase;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign lut_addr_o = st.addr;
  assign freq_active_o = st.freq;
endmodule
`default_nettype wire

// file: hdl/ncp_regs.sv
// What this block does
// - phase offset plus top accumulator half addresses sine and cosine tables.
// - phase register write raises auto-sync when mixer autoload is enabled.
// - auto-sync loads phase and both frequency halves together; halves alone do nothing.
// - frequency word is signed 32-bit, low half then high half.
// - clamp bit grounds loop filter; falling clamp restarts the PLL.
// - divider sync bit, reset one, lets alignment input sync N dividers.
// - synth enable on runs PLL; off bypasses it with input clock.
// - charge pump code 00 none, 01 single, 11 dual, 10 unused.
// - prescaler codes 010..111 divide 2..7, 000 divides by 8.
// - loop filter voltage is read-only 3-bit code; writes ignored.
// - M top bit zero: M equals low seven bits, 4..127 valid.
// - M top bit one: M equals twice low seven bits, 8..254.
// - N ratio equals four-bit code plus one.
// - six-bit VCO coarse band field in bits 15:10 of its register.
//
// Decided for this implementation: register access over Wishbone.
`timescale 1ns/1ns
`default_nettype none
module ncp_regs (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [9:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [2:0] lf_volt_i,
  input wire logic align_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic [15:0] lut_addr_o,
  output logic [31:0] freq_active_o,
  output ncp_pkg::ncp_pll_t pll_o,
  output logic pll_restart_o,
  output logic ndiv_sync_o,
  output logic m_invalid_o
);
  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
    logic [15:0] phase;
    logic [15:0] freq_lo;
    logic [15:0] freq_hi;
    logic [15:0] ctl;
    logic [15:0] div;
    logic [15:0] vco;
    logic [15:0] autoload;
    logic [2:0] lfv;
    logic sync_pulse;
    ncp_pkg::ncp_pll_t pll;
    logic restart;
    logic nsync;
    logic minv;
  } ncp_regs_st_t;

  ncp_regs_st_t st;
  ncp_regs_st_t next_st;
  logic [7:0] idx;
  logic req;
  logic wr;
  logic [15:0] wdata;
  logic [15:0] wmask;

  assign idx = wb_adr_i[9:ncp_pkg::ADDR_LSB];
  assign req = wb_cyc_i && wb_stb_i && !st.ack;
  assign wr = req && wb_we_i;
  assign wmask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  assign wdata = wb_dat_i[15:0];

  function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] d,
                                        input logic [15:0] m, input logic [15:0] keep);
    merge = (old & ~(m & keep)) | (d & m & keep);
  endfunction

  always_comb begin
    logic [15:0] rd;
    logic [6:0] mlow;
    logic [2:0] pcode;
    rd = ncp_pkg::RSVD_VALUE;
    mlow = '0;
    pcode = '0;
    next_st = st;
    next_st.ack = req;
    next_st.sync_pulse = 1'b0;
    next_st.lfv = lf_volt_i;
    if (wr) begin
      unique case (idx)
        ncp_pkg::IDX_PHASE: begin
          next_st.phase = merge(st.phase, wdata, wmask, 16'hffff);
          next_st.sync_pulse = st.autoload[ncp_pkg::AUTOLOAD_EN];
        end
        ncp_pkg::IDX_FREQ_LO: next_st.freq_lo = merge(st.freq_lo, wdata, wmask, 16'hffff);
        ncp_pkg::IDX_FREQ_HI: next_st.freq_hi = merge(st.freq_hi, wdata, wmask, 16'hffff);
        ncp_pkg::IDX_SYNTH_CTL: begin
          next_st.ctl = merge(st.ctl, wdata, wmask, ncp_pkg::CTL_WMASK);
        end
        ncp_pkg::IDX_SYNTH_DIV: next_st.div = merge(st.div, wdata, wmask, ncp_pkg::DIV_WMASK);
        ncp_pkg::IDX_VCO_TUNE: next_st.vco = merge(st.vco, wdata, wmask, ncp_pkg::VCO_WMASK);
        ncp_pkg::IDX_AUTOLOAD: next_st.autoload = merge(st.autoload, wdata, wmask, 16'h0001);
        default: ;
      endcase
    end
    unique case (idx)
      ncp_pkg::IDX_PHASE: rd = st.phase;
      ncp_pkg::IDX_FREQ_LO: rd = st.freq_lo;
      ncp_pkg::IDX_FREQ_HI: rd = st.freq_hi;
      ncp_pkg::IDX_SYNTH_CTL: rd = {st.ctl[15:3], st.lfv};
      ncp_pkg::IDX_SYNTH_DIV: rd = st.div;
      ncp_pkg::IDX_VCO_TUNE: rd = st.vco;
      ncp_pkg::IDX_AUTOLOAD: rd = st.autoload;
      default: rd = ncp_pkg::RSVD_VALUE;
    endcase
    next_st.rdata = (req && !wb_we_i) ? {16'h0000, rd} : 32'h0000_0000;

    // decoded pll controls follow the live register values
    next_st.pll.enable = st.ctl[ncp_pkg::CTL_SYNTH_EN];
    next_st.pll.bypass = !st.ctl[ncp_pkg::CTL_SYNTH_EN];
    next_st.pll.lf_clamp = st.ctl[ncp_pkg::CTL_LF_CLAMP];
    next_st.pll.nsync_en = st.ctl[ncp_pkg::CTL_NSYNC_EN];
    next_st.pll.charge_pump_sel =
      ncp_pkg::ncp_pump_t'(st.ctl[ncp_pkg::CTL_CP_HI:ncp_pkg::CTL_CP_LO]);
    // unused pump code falls back to no pump
    if (st.ctl[ncp_pkg::CTL_CP_HI:ncp_pkg::CTL_CP_LO] == 2'h2) begin
      next_st.pll.charge_pump_sel = ncp_pkg::CP_NONE;
    end
    pcode = st.ctl[ncp_pkg::CTL_PRE_HI:ncp_pkg::CTL_PRE_LO];
    next_st.pll.prescale = (pcode == 3'h0) ? 4'h8 : {1'b0, pcode};
    mlow = st.div[ncp_pkg::DIV_M_HI - 1:ncp_pkg::DIV_M_LO];
    if (st.div[ncp_pkg::DIV_M_HI]) begin
      next_st.pll.m_ratio = {mlow, 1'b0};
      next_st.pll.m_valid = (mlow >= 7'h04);
    end else begin
      next_st.pll.m_ratio = {1'b0, mlow};
      next_st.pll.m_valid = (mlow >= 7'h04);
    end
    // flag kept in its own flop so the pin needs no inverter
    next_st.minv = !next_st.pll.m_valid;
    next_st.pll.n_ratio = {1'b0, st.div[ncp_pkg::DIV_N_HI:ncp_pkg::DIV_N_LO]} + 5'h01;
    next_st.pll.bias_trim = st.div[ncp_pkg::DIV_BIAS_HI:ncp_pkg::DIV_BIAS_LO];
    next_st.pll.vco_band = st.vco[ncp_pkg::VCO_HI:ncp_pkg::VCO_LO];
    // one-cycle restart on the clamp's falling edge
    next_st.restart = st.pll.lf_clamp && !st.ctl[ncp_pkg::CTL_LF_CLAMP];
    next_st.nsync = st.ctl[ncp_pkg::CTL_NSYNC_EN] && align_i;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= '0;
      st.ctl <= ncp_pkg::CTL_RESET;
      st.div <= ncp_pkg::DIV_RESET;
      st.vco <= ncp_pkg::VCO_RESET;
      st.autoload <= ncp_pkg::AUTOLOAD_RESET;
      st.pll.bypass <= 1'b1;
      st.pll.nsync_en <= 1'b1;
      st.pll.prescale <= 4'h1;
      st.pll.m_ratio <= 8'h04;
      st.pll.m_valid <= 1'b1;
      st.pll.n_ratio <= 5'h05;
    end else begin
      st <= next_st;
    end
  end

  // mixer values only reach the nco on an auto-sync
  ncp_nco u_nco (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .load_i(st.sync_pulse),
    .freq_i({st.freq_hi, st.freq_lo}),
    .phase_i(st.phase),
    .lut_addr_o(lut_addr_o),
    .freq_active_o(freq_active_o)
  );

  assign wb_ack_o = st.ack;
  assign wb_dat_o = st.rdata;
  assign pll_o = st.pll;
  assign pll_restart_o = st.restart;
  assign ndiv_sync_o = st.nsync;
  assign m_invalid_o = st.minv;
endmodule
`default_nettype wire

// file: tb/ncp_regs_props.sv
`timescale 1ns/1ns
`default_nettype none
module ncp_regs_props (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic align_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire ncp_pkg::ncp_pll_t pll_o,
  input wire logic pll_restart_o,
  input wire logic ndiv_sync_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not acked");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("data idle");
  a_bypass_pair: assert property (pll_o.bypass != pll_o.enable) else $error("bypass");
  a_pump_code: assert property (pll_o.charge_pump_sel != ncp_pkg::CP_UNUSED)
    else $error("pump code 10 used");
  a_pre_range: assert property (pll_o.prescale inside {[4'h1:4'h8]}) else $error("pre");
  a_n_range: assert property (pll_o.n_ratio inside {[5'h1:5'h10]}) else $error("n");
  // restart pulse lands in the very cycle the decoded clamp drops, and only then
  a_restart_fall:
    assert property (pll_restart_o == $fell(pll_o.lf_clamp))
    else $error("restart pulse mismatch");
  a_ndiv_align:
    assert property (!$past(rst_i) |-> ndiv_sync_o == (pll_o.nsync_en && $past(align_i)))
    else $error("ndiv sync");
endmodule
`default_nettype wire

// file: tb/ncp_regs_tb.sv
`timescale 1ns/1ns
`default_nettype none
module ncp_regs_tb;
  logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, align_i = 0;
  logic [9:0] adr = '0;
  logic [31:0] dat = '0;
  logic [31:0] seed = 32'h9;
  logic [2:0] lfv = 3'h5;
  logic [3:0] sel = 4'h3, lanes = 4'h3;
  logic [15:0] q[$];
  logic [15:0] v, h, l0;
  logic [7:0] rsv[4] = '{8'h13, 8'h16, 8'h17, 8'h30};
  int failures = 0, checks_done = 0;
  wire logic [31:0] dat_o, freq_o;
  wire logic [15:0] lut;
  wire logic ack, restart, nsync, minv;
  wire ncp_pkg::ncp_pll_t pll;
  always #20 clk_i = ~clk_i;
  always @(posedge clk_i) align_i <= ~align_i;
  ncp_regs dut (.clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(dat), .lf_volt_i(lfv), .align_i, .wb_dat_o(dat_o),
    .wb_ack_o(ack), .lut_addr_o(lut), .freq_active_o(freq_o), .pll_o(pll),
    .pll_restart_o(restart), .ndiv_sync_o(nsync), .m_invalid_o(minv));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic bus(input logic [7:0] idx, input logic w, input logic [15:0] d);
    @(posedge clk_i);
    adr <= {idx, 2'b00};
    we <= w;
    dat <= {16'h0, d};
    sel <= lanes;
    cyc <= 1'b1;
    stb <= 1'b1;
    do @(posedge clk_i); while (ack !== 1'b1);
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] idx, input logic [15:0] e);
    q.push_back(e);
    bus(idx, 1'b0, 16'(rnd()));
  endtask
  // lets registered outputs land before they are looked at
  task automatic settle;
    @(posedge clk_i);
    #1;
  endtask
  task automatic stop_test;
    if (failures == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  always @(posedge clk_i) begin
    if (ack === 1'b1 && we === 1'b0) check(dat_o, {16'h0, q.pop_front()}, "read");
  end
  initial begin
    #100000;
    failures++;
    stop_test();
  end
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 8'h12; i < 8'h18; i++) rd(8'(i), 16'h0);
    rd(8'h18, ncp_pkg::CTL_RESET | 16'(lfv));
    rd(8'h19, 16'h0440);
    rd(8'h1a, 16'h0);
    foreach (rsv[i]) begin
      bus(rsv[i], 1'b1, 16'(rnd()));
      rd(rsv[i], 16'h0);
    end
    // crude analog stand-in: a higher band lowers the loop voltage code
    for (int b = 0; b < 8; b++) begin
      bus(8'h1a, 1'b1, 16'(b) << 10);
      lfv <= 3'h7 - 3'(b);
      settle();
      check(pll.vco_band, 6'(b), "vco band");
      rd(8'h18, ncp_pkg::CTL_RESET | 16'(lfv));
      if (lfv inside {[3'h2:3'h5]}) break;
    end
    v = 16'(rnd());
    bus(8'h1a, 1'b1, v);
    rd(8'h1a, v & 16'hfc00);
    lfv <= 3'(rnd());
    bus(8'h18, 1'b1, 16'hffff);
    rd(8'h18, 16'hfff8 | 16'(lfv));
    for (int i = 0; i < 8; i++) begin
      bus(8'h18, 1'b1, {3'h1, i[0], i[2], i[1], 2'h0, i[1:0], i[2:0], 3'h0});
      settle();
      check(pll.enable, i[1], "enable");
      check(pll.bypass, !i[1], "bypass");
      check(pll.nsync_en, i[2], "nsync enable");
      check(pll.lf_clamp, i[0], "clamp");
      check(pll.charge_pump_sel, (i % 4 == 2) ? 2'h0 : 2'(i), "pump");
      check(pll.prescale, (i == 0) ? 4'h8 : 4'(i), "prescale");
    end
    for (int i = 0; i < 8; i++) begin
      v = 16'(rnd()) & ((i < 2) ? 16'h83ff : 16'hffff);
      bus(8'h19, 1'b1, v);
      settle();
      check(pll.m_ratio, v[15] ? {v[14:8], 1'b0} : {1'b0, v[14:8]}, "m ratio");
      check(minv, v[14:8] < 7'h4, "m invalid");
      check(pll.n_ratio, 5'(v[7:4]) + 5'h1, "n ratio");
      rd(8'h19, v & 16'hfffc);
    end
    bus(8'h19, 1'b1, 16'h0444);
    settle();
    check(pll.bias_trim, 2'h1, "bias trim");
    v = 16'(rnd());
    bus(8'h12, 1'b1, v);
    repeat (3) settle();
    check(lut, 16'h0, "no autoload");
    bus(ncp_pkg::IDX_AUTOLOAD, 1'b1, 16'h1);
    bus(8'h12, 1'b1, v);
    repeat (3) settle();
    check(lut, v, "phase offset");
    h = 16'(rnd()) | 16'h8000;
    bus(8'h14, 1'b1, 16'h0);
    bus(8'h15, 1'b1, h);
    repeat (3) settle();
    check(freq_o, 32'h0, "halves alone");
    bus(8'h12, 1'b1, v);
    repeat (3) settle();
    check(freq_o, {h, 16'h0}, "freq word");
    l0 = lut;
    settle();
    check(16'(lut - l0), h, "acc step");
    rd(8'h12, v);
    // low lane only: upper byte of the phase must survive
    lanes = 4'h1;
    bus(8'h12, 1'b1, ~v);
    lanes = 4'h3;
    rd(8'h12, {v[15:8], ~v[7:0]});
    settle();
    stop_test();
  end
endmodule
bind ncp_regs ncp_regs_props props (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .align_i,
  .wb_dat_o, .wb_ack_o, .pll_o, .pll_restart_o, .ndiv_sync_o);
`default_nettype wire
